// >>> rtl/fabric_clock_cfg.svh
// Purpose: constants for the fabric clock distribution block
// Assumes: included by bare name from the package and the modules
// Notes: definitions only
`ifndef FABRIC_CLOCK_CFG_SVH
`define FABRIC_CLOCK_CFG_SVH

// ----------------------------------------
// routing widths and fast line numbers
// ----------------------------------------
`define LONG_LINES 10
`define LINE_SEL_W 4
`define FAST_LINE_LO 8
`define FAST_LINE_HI 9
`define PAIR_PADS 8
`define SEG_PER_CELL 4
`define IO_LOCAL_LINES 5
`define BIDIR_ROUTES 8

// ----------------------------------------
// reset values of the configuration, and the pair segment select bit that picks seg_lower
// ----------------------------------------
`define LINE_SEL_RESET 4'h0
`define PAD_SEL_RESET 3'h0
`define SEG_SEL_RESET 3'h0
`define BIDIR_SEL_RESET 3'h0
`define SEG_SEL_LOWER_BIT 2

`endif

// >>> rtl/fabric_clock_pkg.sv
// Purpose: types shared by the clock distribution modules
// Assumes: fabric_clock_cfg.svh supplies the widths
// Notes: source encodings are configuration codes
package fabric_clock_pkg;
`include "fabric_clock_cfg.svh"

  typedef enum logic [2:0]
  {
    SRC_VLINE = 3'b000,
    SRC_HLINE = 3'b001,
    SRC_NBR_H = 3'b010,
    SRC_NBR_V = 3'b011,
    SRC_LOCAL = 3'b100
  } tile_src_t;

  typedef enum logic [2:0]
  {
    IO_SRC_IO_LINE = 3'b000,
    IO_SRC_END_LINE = 3'b001,
    IO_SRC_ADJ_TILE = 3'b010,
    IO_SRC_NBR_GROUP = 3'b011,
    IO_SRC_SEGMENT = 3'b100
  } io_src_t;

  typedef enum logic [1:0]
  {
    IOCLK_SYS = 2'b00,
    IOCLK_FAST = 2'b01,
    IOCLK_EDGE = 2'b10
  } io_cell_clk_t;

  typedef enum logic [1:0]
  {
    PAIR_PAD = 2'b00,
    PAIR_SEG = 2'b01,
    PAIR_PCM = 2'b10
  } pair_src_t;

  typedef enum logic [1:0]
  {
    EDGE_TOP = 2'b00,
    EDGE_BOTTOM = 2'b01,
    EDGE_LEFT = 2'b10,
    EDGE_RIGHT = 2'b11
  } array_edge_t;

  typedef struct packed
  {
    tile_src_t tile_src;
    logic [`LINE_SEL_W-1:0] vline_sel;
    logic [`LINE_SEL_W-1:0] hline_sel;
    logic [2:0] bidir_sel;
    logic ce_from_vert;
    logic we_from_vert;
    logic set_reset_from_horz;
    logic [`LINE_SEL_W-1:0] hspine_line;
    logic [`LINE_SEL_W-1:0] vspine_line;
    logic hspine_en;
    logic vspine_en;
    logic [1:0] hfast_en;
    logic [1:0] vfast_en;
    io_src_t io_sys_src;
    logic [`LINE_SEL_W-1:0] io_line_sel;
    logic [`LINE_SEL_W-1:0] end_line_sel;
    logic [`LINE_SEL_W-1:0] adj_line_sel;
    logic [`LINE_SEL_W-1:0] nbr_line_sel;
    logic [1:0] seg_sel;
    io_cell_clk_t io_cell_clk;
    logic group_above_ctrl;
    pair_src_t pair_src;
    logic [2:0] pad_sel;
    logic [2:0] pair_seg_sel;
  } cfg_t;

  typedef struct packed
  {
    logic [`LINE_SEL_W-1:0] pick;
    logic spine;
  } pair_state_t;
endpackage

// >>> rtl/io_pair_spine.sv
// Purpose: clock spine source for one pair of io cell groups
// Assumes: pads and segments are synchronous to clk
// Notes: one shared buffer per pair, modelled as one registered select
`timescale 1ns/10ps
`include "fabric_clock_cfg.svh"
module io_pair_spine
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire fabric_clock_pkg::pair_src_t pair_src,
  input wire logic [2:0] pad_sel,
  input wire logic [2:0] seg_sel,
  // sources
  input wire logic [`PAIR_PADS-1:0] pads,
  input wire logic [`SEG_PER_CELL-1:0] seg_upper,
  input wire logic [`SEG_PER_CELL-1:0] seg_lower,
  input wire logic pcm_sys_clk,
  // spine
  output logic spine
);
  import fabric_clock_pkg::*;

  pair_state_t state;
  pair_state_t next_state;

  always_comb
  begin
    next_state = state;
    next_state.pick = {1'b0, seg_sel};
    case (pair_src)
      PAIR_PAD: next_state.spine = pads[pad_sel];
      PAIR_SEG:
      begin
        if (seg_sel[`SEG_SEL_LOWER_BIT])
          next_state.spine = seg_lower[seg_sel[1:0]];
        else
          next_state.spine = seg_upper[seg_sel[1:0]];
      end
      PAIR_PCM: next_state.spine = pcm_sys_clk;
      default: next_state.spine = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state <= '0;
    else
      state <= next_state;
  end

  assign spine = state.spine;
endmodule

// >>> rtl/fabric_clock_distribution.sv
// Purpose: configuration-selected clock routing for one logic tile and one io cell group
// Assumes: all sources are sampled as synchronous levels on clk
// Notes: selections load only on cfg_load, standing in for reconfiguration
`timescale 1ns/10ps
`include "fabric_clock_cfg.svh"
module fabric_clock_distribution
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration load
  input wire logic cfg_load,
  input wire fabric_clock_pkg::cfg_t cfg_in,
  // tile position in the array
  input wire logic row_odd,
  input wire logic col_odd,
  // io pair position
  input wire fabric_clock_pkg::array_edge_t pair_edge,
  // tile long lines, seen level
  input wire logic [`LONG_LINES-1:0] vline_in,
  input wire logic [`LONG_LINES-1:0] hline_in,
  // neighbour tile clocks
  input wire logic nbr_left_clk,
  input wire logic nbr_right_clk,
  input wire logic nbr_above_clk,
  input wire logic nbr_below_clk,
  // local routing
  input wire logic [`BIDIR_ROUTES-1:0] bidir_route,
  // spines arriving at the tile
  input wire logic hspine_left,
  input wire logic hspine_right,
  input wire logic vspine_top,
  input wire logic vspine_bottom,
  input wire logic hfast_spine,
  input wire logic vfast_spine,
  // io pair sources
  input wire logic [`PAIR_PADS-1:0] pair_pads,
  input wire logic [`SEG_PER_CELL-1:0] seg_upper,
  input wire logic [`SEG_PER_CELL-1:0] seg_lower,
  input wire logic pcm_sys_clk,
  // io group routing
  input wire logic [`LONG_LINES-1:0] io_long_line,
  input wire logic [`LONG_LINES-1:0] end_long_line,
  input wire logic [`LONG_LINES-1:0] adj_long_line,
  input wire logic [`LONG_LINES-1:0] nbr_group_line,
  input wire logic [`SEG_PER_CELL-1:0] io_switching_segment,
  // edge clock
  input wire logic edge_pad,
  // tile outputs
  output logic tile_clk,
  output logic tile_ce,
  output logic tile_we,
  output logic tile_set_reset,
  // long line drive from spines
  output logic [`LONG_LINES-1:0] hline_out,
  output logic [`LONG_LINES-1:0] hline_oe,
  output logic [`LONG_LINES-1:0] vline_out,
  output logic [`LONG_LINES-1:0] vline_oe,
  // io pair spine
  output logic pair_spine,
  output logic pair_spine_left_col,
  output logic pair_spine_from_left,
  // io group outputs
  output logic [`IO_LOCAL_LINES-1:0] io_local,
  output logic io_sys_clk,
  output logic io_cell_clk,
  // middle controller outputs
  output logic fast_spine_out,
  output logic edge_wire_hi,
  output logic edge_wire_lo
);
  import fabric_clock_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed
  {
    cfg_t cfg;
    logic tile_clk;
    logic tile_ce;
    logic tile_we;
    logic tile_set_reset;
    logic [`LONG_LINES-1:0] hline_out;
    logic [`LONG_LINES-1:0] hline_oe;
    logic [`LONG_LINES-1:0] vline_out;
    logic [`LONG_LINES-1:0] vline_oe;
    logic pair_spine;
    logic pair_spine_left_col;
    logic pair_spine_from_left;
    logic [`IO_LOCAL_LINES-1:0] io_local;
    logic io_sys_clk;
    logic io_cell_clk;
    logic fast_spine_out;
    logic edge_wire_hi;
    logic edge_wire_lo;
  } dist_state_t;

  dist_state_t state;
  dist_state_t next_state;
  logic pair_spine_raw;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // an out-of-range index picks nothing rather than wrapping
  function automatic logic pick_line(input logic [`LONG_LINES-1:0] lines,
                                     input logic [`LINE_SEL_W-1:0] sel);
    logic hit;
    hit = 1'b0;
    if (sel < 4'hA)
      hit = lines[sel];
    return hit;
  endfunction

  // one-hot drive of a single long line
  function automatic logic [`LONG_LINES-1:0] line_hot(input logic [`LINE_SEL_W-1:0] sel);
    logic [`LONG_LINES-1:0] hot;
    hot = '0;
    if (sel < 4'hA)
      hot[sel] = 1'b1;
    return hot;
  endfunction

  function automatic cfg_t cfg_reset();
    cfg_t c;
    c = '0;
    c.tile_src = SRC_VLINE;
    c.vline_sel = `LINE_SEL_RESET;
    c.hline_sel = `LINE_SEL_RESET;
    c.bidir_sel = `BIDIR_SEL_RESET;
    c.io_sys_src = IO_SRC_IO_LINE;
    c.io_cell_clk = IOCLK_SYS;
    c.pair_src = PAIR_PAD;
    c.pad_sel = `PAD_SEL_RESET;
    c.pair_seg_sel = `SEG_SEL_RESET;
    return c;
  endfunction

  // ----------------------------------------
  // io pair spine buffer
  // ----------------------------------------
  io_pair_spine u_pair
  (
    .clk(clk),
    .reset(reset),
    .pair_src(state.cfg.pair_src),
    .pad_sel(state.cfg.pad_sel),
    .seg_sel(state.cfg.pair_seg_sel),
    .pads(pair_pads),
    .seg_upper(seg_upper),
    .seg_lower(seg_lower),
    .pcm_sys_clk(pcm_sys_clk),
    .spine(pair_spine_raw)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic vclk;
    logic hclk;
    logic nbr_h;
    logic nbr_v;
    logic local_ctl;
    logic hspine;
    logic vspine;
    logic [`LONG_LINES-1:0] fast_hot;
    logic edge_clk;
    vclk = 1'b0;
    hclk = 1'b0;
    nbr_h = 1'b0;
    nbr_v = 1'b0;
    local_ctl = 1'b0;
    hspine = 1'b0;
    vspine = 1'b0;
    fast_hot = '0;
    edge_clk = 1'b0;
    next_state = state;

    // selections hold until a reconfiguration load
    if (cfg_load)
      next_state.cfg = cfg_in;

    // tile clock sources
    vclk = pick_line(vline_in, state.cfg.vline_sel);
    hclk = pick_line(hline_in, state.cfg.hline_sel);
    nbr_h = col_odd ? nbr_right_clk : nbr_left_clk;
    nbr_v = row_odd ? nbr_below_clk : nbr_above_clk;
    local_ctl = bidir_route[state.cfg.bidir_sel];
    case (state.cfg.tile_src)
      SRC_VLINE: next_state.tile_clk = vclk;
      SRC_HLINE: next_state.tile_clk = hclk;
      SRC_NBR_H: next_state.tile_clk = nbr_h;
      SRC_NBR_V: next_state.tile_clk = nbr_v;
      SRC_LOCAL: next_state.tile_clk = local_ctl;
      default: next_state.tile_clk = 1'b0;
    endcase

    // control inputs ride on the clock routes for low skew
    next_state.tile_ce = state.cfg.ce_from_vert & vclk;
    next_state.tile_we = state.cfg.we_from_vert & vclk;
    next_state.tile_set_reset = state.cfg.set_reset_from_horz & hclk;

    // one spine each way, source side alternating by parity
    hspine = row_odd ? hspine_right : hspine_left;
    vspine = col_odd ? vspine_bottom : vspine_top;

    // vertical spine drives horizontal lines, horizontal spine vertical ones
    next_state.hline_oe = state.cfg.vspine_en ? line_hot(state.cfg.vspine_line) : '0;
    next_state.vline_oe = state.cfg.hspine_en ? line_hot(state.cfg.hspine_line) : '0;
    next_state.hline_out = {`LONG_LINES{vspine}};
    next_state.vline_out = {`LONG_LINES{hspine}};

    // fast spines only reach lines 8 and 9; they win over a system spine there
    fast_hot = '0;
    fast_hot[`FAST_LINE_LO] = state.cfg.vfast_en[0];
    fast_hot[`FAST_LINE_HI] = state.cfg.vfast_en[1];
    next_state.hline_oe = next_state.hline_oe | fast_hot;
    if (state.cfg.vfast_en[0])
      next_state.hline_out[`FAST_LINE_LO] = vfast_spine;
    if (state.cfg.vfast_en[1])
      next_state.hline_out[`FAST_LINE_HI] = vfast_spine;
    fast_hot = '0;
    fast_hot[`FAST_LINE_LO] = state.cfg.hfast_en[0];
    fast_hot[`FAST_LINE_HI] = state.cfg.hfast_en[1];
    next_state.vline_oe = next_state.vline_oe | fast_hot;
    if (state.cfg.hfast_en[0])
      next_state.vline_out[`FAST_LINE_LO] = hfast_spine;
    if (state.cfg.hfast_en[1])
      next_state.vline_out[`FAST_LINE_HI] = hfast_spine;

    // pair spine placement
    next_state.pair_spine = pair_spine_raw;
    next_state.pair_spine_left_col = (pair_edge == EDGE_TOP);
    next_state.pair_spine_from_left = (pair_edge == EDGE_LEFT);

    // middle controller: edge pad to fast spine and two edge wires
    edge_clk = edge_pad;
    next_state.fast_spine_out = edge_clk;
    next_state.edge_wire_hi = edge_clk;
    next_state.edge_wire_lo = edge_clk;

    // io group local clock lines
    next_state.io_local[0] = pick_line(io_long_line, state.cfg.io_line_sel);
    next_state.io_local[1] = pick_line(end_long_line, state.cfg.end_line_sel);
    next_state.io_local[2] = pick_line(adj_long_line, state.cfg.adj_line_sel);
    next_state.io_local[3] = pick_line(nbr_group_line, state.cfg.nbr_line_sel);
    next_state.io_local[4] = io_switching_segment[state.cfg.seg_sel];
    case (state.cfg.io_sys_src)
      IO_SRC_IO_LINE: next_state.io_sys_clk = state.io_local[0];
      IO_SRC_END_LINE: next_state.io_sys_clk = state.io_local[1];
      IO_SRC_ADJ_TILE: next_state.io_sys_clk = state.io_local[2];
      IO_SRC_NBR_GROUP: next_state.io_sys_clk = state.io_local[3];
      IO_SRC_SEGMENT: next_state.io_sys_clk = state.io_local[4];
      default: next_state.io_sys_clk = 1'b0;
    endcase

    // io cell register clock; edge clock taken from the wire on this group's side
    case (state.cfg.io_cell_clk)
      IOCLK_SYS: next_state.io_cell_clk = state.io_sys_clk;
      IOCLK_FAST: next_state.io_cell_clk = state.fast_spine_out;
      IOCLK_EDGE:
      begin
        if (state.cfg.group_above_ctrl)
          next_state.io_cell_clk = state.edge_wire_hi;
        else
          next_state.io_cell_clk = state.edge_wire_lo;
      end
      default: next_state.io_cell_clk = 1'b0;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= '0;
      state.cfg <= cfg_reset();
    end
    else
      state <= next_state;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign tile_clk = state.tile_clk;
  assign tile_ce = state.tile_ce;
  assign tile_we = state.tile_we;
  assign tile_set_reset = state.tile_set_reset;
  assign hline_out = state.hline_out;
  assign hline_oe = state.hline_oe;
  assign vline_out = state.vline_out;
  assign vline_oe = state.vline_oe;
  assign pair_spine = state.pair_spine;
  assign pair_spine_left_col = state.pair_spine_left_col;
  assign pair_spine_from_left = state.pair_spine_from_left;
  assign io_local = state.io_local;
  assign io_sys_clk = state.io_sys_clk;
  assign io_cell_clk = state.io_cell_clk;
  assign fast_spine_out = state.fast_spine_out;
  assign edge_wire_hi = state.edge_wire_hi;
  assign edge_wire_lo = state.edge_wire_lo;
endmodule

// >>> verification/clock_source_model.sv
// Purpose: model of the pads, clock manager and fabric signals that feed the block
// Assumes: every source is a level that moves just after a rising edge
// Notes: fresh random levels each cycle, so no source keeps a stale value
`timescale 1ns/10ps
module clock_source_model
(
  // clock
  input wire logic clk,
  // all source levels, packed in the bench's order
  output logic [99:0] src
);
  // ----------------------------------------
  // source levels
  // ----------------------------------------
  initial src = 100'h0;
  always @(posedge clk)
  begin
    logic [127:0] r;
    r = {$urandom, $urandom, $urandom, $urandom};
    #1;
    src <= r[99:0];
  end
endmodule

// >>> verification/fabric_clock_distribution_monitor.sv
// Purpose: port-level assertions for the fabric clock distribution block
// Assumes: config follows cfg_load only; outputs are registered
// Notes: the copy of the selections mirrors the load, not the routing
`timescale 1ns/10ps
`include "fabric_clock_cfg.svh"
module fabric_clock_distribution_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // inputs watched
  input wire logic cfg_load,
  input wire fabric_clock_pkg::cfg_t cfg_in,
  input wire logic col_odd,
  input wire fabric_clock_pkg::array_edge_t pair_edge,
  input wire logic [`LONG_LINES-1:0] vline_in,
  input wire logic nbr_left_clk,
  input wire logic nbr_right_clk,
  input wire logic [`BIDIR_ROUTES-1:0] bidir_route,
  input wire logic vspine_top,
  input wire logic vspine_bottom,
  input wire logic vfast_spine,
  input wire logic [`PAIR_PADS-1:0] pair_pads,
  input wire logic edge_pad,
  // outputs watched
  input wire logic tile_clk,
  input wire logic [`LONG_LINES-1:0] hline_out,
  input wire logic [`LONG_LINES-1:0] hline_oe,
  input wire logic pair_spine,
  input wire logic pair_spine_left_col,
  input wire logic pair_spine_from_left,
  input wire logic fast_spine_out,
  input wire logic edge_wire_hi,
  input wire logic edge_wire_lo
);
  import fabric_clock_pkg::*;
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  cfg_t cfg_q;
  logic vl_pick;
  logic nbr_pick;
  logic bd_pick;
  logic pad_pick;
  logic vsp_pick;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cfg_q <= '0;
    else if (cfg_load)
      cfg_q <= cfg_in;
  end
  // out-of-range selects give x here, so they are excluded below
  assign vl_pick = vline_in[cfg_q.vline_sel];
  assign nbr_pick = col_odd ? nbr_right_clk : nbr_left_clk;
  assign bd_pick = bidir_route[cfg_q.bidir_sel];
  assign pad_pick = pair_pads[cfg_q.pad_sel];
  assign vsp_pick = col_odd ? vspine_bottom : vspine_top;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_vline_tile_clock: assert property (
    cfg_q.tile_src == SRC_VLINE && cfg_q.vline_sel < 4'hA |=> tile_clk == $past(vl_pick))
    else $error("tile clock does not follow the chosen vertical line");
  a_neighbour_side: assert property (
    cfg_q.tile_src == SRC_NBR_H |=> tile_clk == $past(nbr_pick))
    else $error("tile clock does not follow the neighbour on the chosen side");
  a_local_route_clock: assert property (
    cfg_q.tile_src == SRC_LOCAL |=> tile_clk == $past(bd_pick))
    else $error("tile clock does not follow the local route");
  a_fast_line_nine: assert property (
    cfg_q.vfast_en[1] |=> hline_oe[9] && hline_out[9] == $past(vfast_spine))
    else $error("fast spine not on line nine");
  a_spine_one_line: assert property (
    cfg_q.vspine_en && cfg_q.vspine_line < 4'h8 && cfg_q.vfast_en == 2'b00
    |=> hline_oe == (10'h001 << $past(cfg_q.vspine_line))
    && hline_out[$past(cfg_q.vspine_line)] == $past(vsp_pick))
    else $error("spine does not drive exactly its one line");
  a_pair_pad_path: assert property (
    cfg_q.pair_src == PAIR_PAD && !cfg_load |=> ##1 pair_spine == $past(pad_pick, 2))
    else $error("pair spine does not follow the chosen pad");
  a_pair_placement: assert property (
    1'b1 |=> pair_spine_left_col == ($past(pair_edge) == EDGE_TOP)
    && pair_spine_from_left == ($past(pair_edge) == EDGE_LEFT))
    else $error("pair placement flags wrong for the edge");
  a_edge_two_wires: assert property (
    1'b1 |=> {fast_spine_out, edge_wire_hi, edge_wire_lo} == {3{$past(edge_pad)}})
    else $error("edge clock wires do not follow the edge pad");
  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_local_loaded: cover property (cfg_load ##1 cfg_q.tile_src == SRC_LOCAL);
  c_pair_segment: cover property (cfg_q.pair_src == PAIR_SEG && pair_spine);
  c_fast_line: cover property (cfg_q.vfast_en[0] && hline_oe[8]);
endmodule

bind fabric_clock_distribution fabric_clock_distribution_monitor mon
(
  .clk(clk), .reset(reset), .cfg_load(cfg_load), .cfg_in(cfg_in), .col_odd(col_odd),
  .pair_edge(pair_edge), .vline_in(vline_in), .nbr_left_clk(nbr_left_clk),
  .nbr_right_clk(nbr_right_clk), .bidir_route(bidir_route), .vspine_top(vspine_top),
  .vspine_bottom(vspine_bottom), .vfast_spine(vfast_spine), .pair_pads(pair_pads),
  .edge_pad(edge_pad), .tile_clk(tile_clk), .hline_out(hline_out), .hline_oe(hline_oe),
  .pair_spine(pair_spine), .pair_spine_left_col(pair_spine_left_col),
  .pair_spine_from_left(pair_spine_from_left), .fast_spine_out(fast_spine_out),
  .edge_wire_hi(edge_wire_hi), .edge_wire_lo(edge_wire_lo)
);

// >>> verification/tb_fabric_clock_distribution.sv
// Purpose: self-checking bench for the fabric clock distribution block
// Assumes: outputs registered; selections move only on cfg_load
// Notes: expectations lag the outputs by one to three source samples
`timescale 1ns/10ps
`include "fabric_clock_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_fabric_clock_distribution;
  import fabric_clock_pkg::*;
  typedef struct packed
  {
    logic [9:0] vl; logic [9:0] hl; logic nl; logic nr; logic na; logic nb;
    logic [7:0] bd; logic hsl; logic hsr; logic vst; logic vsb; logic hf; logic vf;
    logic [7:0] pads; logic [3:0] su; logic [3:0] sl; logic pcm; logic [9:0] iol;
    logic [9:0] endl; logic [9:0] adj; logic [9:0] ngl; logic [3:0] seg; logic ep;
  } src_t;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cfg_load = 1'b0;
  cfg_t cfg_in = '0;
  logic row_odd = 1'b0;
  logic col_odd = 1'b0;
  array_edge_t pair_edge = EDGE_TOP;
  logic [99:0] src;
  src_t s;
  logic tile_clk, tile_ce, tile_we, tile_set_reset, pair_spine, pair_spine_left_col;
  logic pair_spine_from_left, io_sys_clk, io_cell_clk, fast_spine_out, edge_wire_hi;
  logic edge_wire_lo;
  logic [9:0] hline_out, hline_oe, vline_out, vline_oe;
  logic [4:0] io_local;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  assign s = src;
  always #2 clk = ~clk;
  clock_source_model partner (.clk(clk), .src(src));
  fabric_clock_distribution uut
  (
    .clk(clk), .reset(reset), .cfg_load(cfg_load), .cfg_in(cfg_in), .row_odd(row_odd),
    .col_odd(col_odd), .pair_edge(pair_edge), .vline_in(s.vl), .hline_in(s.hl),
    .nbr_left_clk(s.nl), .nbr_right_clk(s.nr), .nbr_above_clk(s.na), .nbr_below_clk(s.nb),
    .bidir_route(s.bd), .hspine_left(s.hsl), .hspine_right(s.hsr), .vspine_top(s.vst),
    .vspine_bottom(s.vsb), .hfast_spine(s.hf), .vfast_spine(s.vf), .pair_pads(s.pads),
    .seg_upper(s.su), .seg_lower(s.sl), .pcm_sys_clk(s.pcm), .io_long_line(s.iol),
    .end_long_line(s.endl), .adj_long_line(s.adj), .nbr_group_line(s.ngl),
    .io_switching_segment(s.seg), .edge_pad(s.ep), .tile_clk(tile_clk), .tile_ce(tile_ce),
    .tile_we(tile_we), .tile_set_reset(tile_set_reset), .hline_out(hline_out),
    .hline_oe(hline_oe),
    .vline_out(vline_out), .vline_oe(vline_oe), .pair_spine(pair_spine),
    .pair_spine_left_col(pair_spine_left_col), .pair_spine_from_left(pair_spine_from_left),
    .io_local(io_local), .io_sys_clk(io_sys_clk), .io_cell_clk(io_cell_clk),
    .fast_spine_out(fast_spine_out), .edge_wire_hi(edge_wire_hi), .edge_wire_lo(edge_wire_lo)
  );
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  // a select of ten or more picks nothing
  function automatic logic pick(logic [9:0] l, logic [3:0] sel);
    return (sel < 4'hA) ? l[sel] : 1'b0;
  endfunction
  function automatic logic exp_tile(cfg_t c, src_t x);
    case (c.tile_src)
      SRC_VLINE: return pick(x.vl, c.vline_sel);
      SRC_HLINE: return pick(x.hl, c.hline_sel);
      SRC_NBR_H: return col_odd ? x.nr : x.nl;
      SRC_NBR_V: return row_odd ? x.nb : x.na;
      default: return x.bd[c.bidir_sel];
    endcase
  endfunction
  function automatic logic exp_pair(cfg_t c, src_t x);
    case (c.pair_src)
      PAIR_PAD: return x.pads[c.pad_sel];
      PAIR_SEG: return c.pair_seg_sel[2] ? x.sl[c.pair_seg_sel[1:0]] : x.su[c.pair_seg_sel[1:0]];
      PAIR_PCM: return x.pcm;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [9:0] exp_oe(logic en, logic [3:0] line, logic [1:0] fe);
    logic [9:0] m;
    m = (en && line < 4'hA) ? (10'h001 << line) : 10'h000;
    m[8] = m[8] | fe[0];
    m[9] = m[9] | fe[1];
    return m;
  endfunction
  // fast spine wins on lines 8 and 9 when enabled
  function automatic logic [9:0] exp_out(logic sp, logic [1:0] fe, logic f);
    logic [9:0] m;
    m = {10{sp}};
    if (fe[0])
      m[8] = f;
    if (fe[1])
      m[9] = f;
    return m;
  endfunction
  function automatic logic [4:0] exp_loc(cfg_t c, src_t x);
    return {x.seg[c.seg_sel], pick(x.ngl, c.nbr_line_sel), pick(x.adj, c.adj_line_sel),
      pick(x.endl, c.end_line_sel), pick(x.iol, c.io_line_sel)};
  endfunction
  // ----------------------------------------
  // one configuration, then many sampled cycles
  // ----------------------------------------
  task automatic run(input cfg_t c, input logic load);
    src_t s1, s2, s3;
    logic [4:0] e1, e2, e3;
    logic [63:0] r;
    int k;
    if (load)
    begin
      cfg_load = 1'b1;
      cfg_in = c;
      @(posedge clk);
      #1;
      cfg_load = 1'b0;
    end
    for (k = 0; k < 24; k++)
    begin
      @(posedge clk);
      #1;
      // garbage on cfg_in while not loading must change nothing
      r = {$urandom, $urandom};
      cfg_in = r[$bits(cfg_t)-1:0];
      @(negedge clk);
      if (k >= 2)
      begin
        e1 = exp_loc(c, s1);
        e2 = exp_loc(c, s2);
        e3 = exp_loc(c, s3);
        `CHK(tile_clk, exp_tile(c, s1))
        `CHK(tile_ce, c.ce_from_vert & pick(s1.vl, c.vline_sel))
        `CHK(tile_we, c.we_from_vert & pick(s1.vl, c.vline_sel))
        `CHK(tile_set_reset, c.set_reset_from_horz & pick(s1.hl, c.hline_sel))
        `CHK(hline_oe, exp_oe(c.vspine_en, c.vspine_line, c.vfast_en))
        `CHK(vline_oe, exp_oe(c.hspine_en, c.hspine_line, c.hfast_en))
        `CHK(hline_out, exp_out(col_odd ? s1.vsb : s1.vst, c.vfast_en, s1.vf))
        `CHK(vline_out, exp_out(row_odd ? s1.hsr : s1.hsl, c.hfast_en, s1.hf))
        `CHK(pair_spine, exp_pair(c, s2))
        `CHK(pair_spine_left_col, pair_edge == EDGE_TOP)
        `CHK(pair_spine_from_left, pair_edge == EDGE_LEFT)
        `CHK(io_local, e1)
        `CHK({fast_spine_out, edge_wire_hi, edge_wire_lo}, {3{s1.ep}})
        `CHK(io_sys_clk, e2[c.io_sys_src])
        if (c.io_cell_clk != IOCLK_SYS) `CHK(io_cell_clk, s2.ep)
        else if (k >= 3) `CHK(io_cell_clk, e3[c.io_sys_src])
      end
      s3 = s2;
      s2 = s1;
      s1 = s;
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    cfg_t c;
    logic [63:0] r;
    int i;
    void'($urandom(32'h462dabd0));
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    run('0, 1'b0);
    for (i = 0; i < 30; i++)
    begin
      r = {$urandom, $urandom};
      c = r[$bits(cfg_t)-1:0];
      c.tile_src = tile_src_t'(i % 5);
      c.pair_src = pair_src_t'(i % 4);
      c.io_cell_clk = io_cell_clk_t'(i % 3);
      c.io_sys_src = io_src_t'(i % 5);
      c.vline_sel = 4'($urandom_range(9));
      c.hline_sel = (i == 11) ? 4'hF : 4'($urandom_range(9));
      c.vspine_line = (i == 7) ? 4'hC : ((i == 12) ? 4'h9 : 4'($urandom_range(9)));
      if (i == 5)
        c.vline_sel = 4'hA;
      @(posedge clk);
      #1;
      row_odd = 1'($urandom);
      col_odd = 1'($urandom);
      pair_edge = array_edge_t'($urandom_range(3));
      run(c, 1'b1);
    end
    // reset in mid-run: all outputs low, selections back to codes of zero
    @(posedge clk);
    #1;
    reset = 1'b1;
    @(negedge clk);
    `CHK({tile_clk, pair_spine, io_cell_clk, hline_oe, io_local}, 18'h00000)
    @(posedge clk);
    #1;
    reset = 1'b0;
    run('0, 1'b0);
    report_and_stop();
  end
endmodule
